// ### verilog/tagged_input_loader.sv
// Purpose: Host side input of the graphics core: register writes,
//          direct window and buffer transfers into one entry queue.
// Assumes: Wishbone classic slave, same clock as the system bus.
// Notes:   Entries leave on the drain port as target register writes.

`timescale 1ns/1ns

module tagged_input_loader #(
   parameter int DEPTH = loader_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [loader_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic [31:0]                        wb_dat_o,
   output logic                               wb_ack_o,
   // Host memory read port
   output logic                               mem_req,
   output logic [31:0]                        mem_addr,
   input  wire logic [31:0]                   mem_rdata,
   input  wire logic                          mem_ack,
   // Drain side towards the graphics core
   input  wire logic                          drain_req,
   output logic                               entry_strobe,
   output logic [loader_pkg::TAG_W-1:0]       entry_tag,
   output logic [31:0]                        entry_data,
   // Completion interrupt
   output logic                               irq
);

   localparam int TW = loader_pkg::TAG_W;
   localparam int CW = loader_pkg::COUNT_W;
   localparam int FW = $clog2(DEPTH+1);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] ofs);
      hit = (a[15:2] == ofs[15:2]);
   endfunction

   function automatic logic [3:0] first_set(input logic [15:0] m);
      first_set = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) begin
            first_set = 4'(i);
         end
      end
   endfunction

   logic          bus_req;
   logic          wr_now;
   logic          rd_cap;
   logic          reg_wr;
   logic          ap_wr;
   logic          on_win;

   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_now  = bus_req & wb_ack_o & wb_we_i & (wb_sel_i == 4'hF);
   assign rd_cap  = bus_req & ~wb_ack_o & ~wb_we_i;
   assign on_win  = (wb_adr_i[15:12] == loader_pkg::PAGE_WIN);
   assign ap_wr   = wr_now & on_win;
   assign reg_wr  = wr_now & (wb_adr_i[15:12] == loader_pkg::PAGE_REGS);

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   logic [31:0]   transfer_base_pointer;
   logic          interrupt_enable_reg;
   logic          transfer_done_flag;
   logic [CW-1:0] transfer_word_counter;
   logic [FW-1:0] input_queue_free_count;
   logic          start;
   logic          done;
   logic          flag_clr;

   assign start = wr_now & hit(wb_adr_i, loader_pkg::OFS_COUNT)
                  & (wb_dat_i[CW-1:0] != '0);
   assign flag_clr = wr_now & hit(wb_adr_i, loader_pkg::OFS_IFLAG)
                     & wb_dat_i[loader_pkg::DONE_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         transfer_base_pointer <= loader_pkg::RST_WORD;
         interrupt_enable_reg  <= 1'b0;
      end else begin
         if (wr_now & hit(wb_adr_i, loader_pkg::OFS_BASE)) begin
            transfer_base_pointer <= wb_dat_i;
         end
         if (wr_now & hit(wb_adr_i, loader_pkg::OFS_IEN)) begin
            interrupt_enable_reg <= wb_dat_i[loader_pkg::DONE_BIT];
         end
      end
   end

   // A completion in the clearing cycle keeps the flag set.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         transfer_done_flag <= 1'b0;
         irq                <= 1'b0;
      end else begin
         transfer_done_flag <= done | (transfer_done_flag & ~flag_clr);
         irq <= interrupt_enable_reg & (done | (transfer_done_flag & ~flag_clr));
      end
   end

   // Window reads and unmapped reads answer zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= loader_pkg::RST_WORD;
      end else if (rd_cap) begin
         wb_dat_o <= loader_pkg::RST_WORD;
         if (wb_adr_i[15:12] == 4'h0) begin
            if (hit(wb_adr_i, loader_pkg::OFS_FREE)) begin
               wb_dat_o <= 32'(input_queue_free_count);
            end
            if (hit(wb_adr_i, loader_pkg::OFS_BASE)) begin
               wb_dat_o <= transfer_base_pointer;
            end
            if (hit(wb_adr_i, loader_pkg::OFS_COUNT)) begin
               wb_dat_o <= 32'(transfer_word_counter);
            end
            if (hit(wb_adr_i, loader_pkg::OFS_IEN)) begin
               wb_dat_o <= 32'(interrupt_enable_reg);
            end
            if (hit(wb_adr_i, loader_pkg::OFS_IFLAG)) begin
               wb_dat_o <= 32'(transfer_done_flag);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Transfer engine
   // ----------------------------------------------------------------
   logic          dma_valid;
   logic [31:0]   dma_word;
   logic          dma_take;
   logic          q_full;

   transfer_fetch #(
      .COUNT_W (CW)
   ) u_fetch (
      .clk         (clk),
      .rst         (rst),
      .start       (start),
      .start_addr  (transfer_base_pointer),
      .start_count (wb_dat_i[CW-1:0]),
      .room        (~q_full),
      .remaining   (transfer_word_counter),
      .done        (done),
      .mem_req     (mem_req),
      .mem_addr    (mem_addr),
      .mem_rdata   (mem_rdata),
      .mem_ack     (mem_ack),
      .word_valid  (dma_valid),
      .word_data   (dma_word),
      .word_take   (dma_take)
   );

   // ----------------------------------------------------------------
   // Description word parser
   // ----------------------------------------------------------------
   loader_pkg::parse_state_t state;
   logic [1:0]    fmt;
   logic [TW-1:0] tag;
   logic [CW-1:0] left;
   logic [15:0]   mask;
   logic [TW-1:0] cur_tag;
   logic [31:0]   in_word;
   logic          in_valid;
   logic          take;
   logic          par_push;
   logic          last;
   logic [15:0]   next_mask;

   // Window words come first, the engine waits a cycle.
   assign in_valid = ap_wr | dma_valid;
   assign in_word  = ap_wr ? wb_dat_i : dma_word;
   assign dma_take = dma_valid & ~ap_wr & take;

   always_comb begin
      if (state == loader_pkg::PS_DESC) begin
         take = in_valid;
      end else begin
         take = ap_wr | (dma_valid & ~q_full & ~reg_wr);
      end
   end

   assign par_push  = take & (state == loader_pkg::PS_DATA) & ~q_full;
   assign next_mask = mask & (mask - 16'h0001);

   always_comb begin
      if (fmt == loader_pkg::FMT_IDX) begin
         cur_tag = {tag[TW-1:loader_pkg::GROUP_LSB], first_set(mask)};
         last    = (next_mask == 16'h0000);
      end else begin
         cur_tag = tag;
         last    = (left == '0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= loader_pkg::PS_DESC;
         fmt   <= loader_pkg::FMT_HOLD;
         tag   <= '0;
         left  <= '0;
         mask  <= 16'h0000;
      end else if (take) begin
         unique case (state)
            loader_pkg::PS_DESC: begin
               fmt  <= in_word[loader_pkg::FMT_LSB +: 2];
               tag  <= in_word[loader_pkg::TAG_LSB +: TW];
               left <= in_word[loader_pkg::CNT_LSB +: CW];
               mask <= in_word[loader_pkg::CNT_LSB +: 16];
               if ((in_word[loader_pkg::FMT_LSB +: 2] != loader_pkg::FMT_IDX)
                   || (in_word[loader_pkg::CNT_LSB +: 16] != 16'h0000)) begin
                  state <= loader_pkg::PS_DATA;
               end
            end
            loader_pkg::PS_DATA: begin
               left <= left - 1'b1;
               mask <= next_mask;
               if (fmt == loader_pkg::FMT_INC) begin
                  tag <= tag + 1'b1;
               end
               if (last) begin
                  state <= loader_pkg::PS_DESC;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Input queue
   // ----------------------------------------------------------------
   logic                  q_push;
   logic [TW+31:0]        q_data;
   logic [TW+31:0]        q_out;

   // Register writes win the queue; a full queue drops them.
   assign q_push = reg_wr ? ~q_full : par_push;
   assign q_data = reg_wr ? {wb_adr_i[loader_pkg::REG_TAG_LSB +: TW], wb_dat_i}
                          : {cur_tag, in_word};

   entry_queue #(
      .WIDTH (TW + 32),
      .DEPTH (DEPTH)
   ) u_queue (
      .clk        (clk),
      .rst        (rst),
      .push       (q_push),
      .push_data  (q_data),
      .full       (q_full),
      .free_count (input_queue_free_count),
      .pop_req    (drain_req),
      .out_strobe (entry_strobe),
      .out_data   (q_out)
   );

   assign entry_tag  = q_out[TW+31:32];
   assign entry_data = q_out[31:0];

endmodule

// ### verilog/loader_pkg.sv
// Purpose: Shared constants for the tagged input queue and transfer loader.
// Assumes: One 20 MHz clock, asynchronous active-high reset.
// Notes:   Byte offsets are Wishbone byte addresses of 32-bit registers.
//
// What this block does
// - Register write into full queue is dropped.
// - Queue holds 32 tag plus data entries.
// - Target register updates only when entry pops.
// - Free count never reports more than 32.
// - Free count tracks every push and pop.
// - 4K byte window writes go into queue.
// - Window reads return nothing; whole words only.
// - Engine fetches buffers under 64K words.
// - Count write starts transfer at base pointer.
// - Fetching stalls while the queue is full.
// - Base pointer latched when transfer starts.
// - Engine only reads host buffer memory.
// - Buffer is description word then data words.
// - Two-bit format picks hold, increment, indexed.
// - Hold: nine-bit tag, count minus one, same tag.
// - Format zero, count zero: plain tag/data pair.
// - Increment: tag advances after each data word.
// - Indexed: group bits, mask loads ascending tags.
// - Counter decrements; reaching zero sets done flag.

package loader_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int QUEUE_DEPTH = 32;
   localparam int TAG_W       = 9;
   localparam int DATA_W      = 32;
   localparam int COUNT_W     = 16;
   localparam int ADR_W       = 16;

   // ----------------------------------------------------------------
   // Register byte offsets and address windows
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_FREE   = 16'h0000;
   localparam logic [15:0] OFS_BASE   = 16'h0004;
   localparam logic [15:0] OFS_COUNT  = 16'h0008;
   localparam logic [15:0] OFS_IEN    = 16'h000C;
   localparam logic [15:0] OFS_IFLAG  = 16'h0010;
   localparam logic [3:0]  PAGE_WIN   = 4'h2;
   localparam logic [3:0]  PAGE_REGS  = 4'h4;
   localparam int          REG_TAG_LSB = 3;

   // ----------------------------------------------------------------
   // Description word fields
   // ----------------------------------------------------------------
   localparam int TAG_LSB   = 0;
   localparam int GROUP_LSB = 4;
   localparam int FMT_LSB   = 14;
   localparam int CNT_LSB   = 16;
   localparam logic [1:0] FMT_HOLD = 2'h0;
   localparam logic [1:0] FMT_INC  = 2'h1;
   localparam logic [1:0] FMT_IDX  = 2'h2;
   localparam int DONE_BIT  = 0;

   // ----------------------------------------------------------------
   // Reset values and steps
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

   typedef enum logic {
      PS_DESC = 1'b0,
      PS_DATA = 1'b1
   } parse_state_t;

endpackage

// ### verilog/entry_queue.sv
// Purpose: Tag plus data queue with a registered pop port.
// Assumes: Push is never offered while full is high.
// Notes:   Free count is a register of its own.

`timescale 1ns/1ns

module entry_queue #(
   parameter int WIDTH = 41,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Fill side
   input  wire logic                       push,
   input  wire logic [WIDTH-1:0]           push_data,
   output logic                            full,
   output logic [$clog2(DEPTH+1)-1:0]      free_count,
   // Drain side
   input  wire logic                       pop_req,
   output logic                            out_strobe,
   output logic [WIDTH-1:0]                out_data
);

   localparam int PW = $clog2(DEPTH);
   localparam int FW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic             pop;
   logic             do_push;

   assign full    = (free_count == '0);
   assign do_push = push & ~full;
   assign pop     = pop_req & (free_count != FW'(DEPTH));

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Free count moves by one per pop up and per push down.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         free_count <= FW'(DEPTH);
      end else if (pop & ~do_push) begin
         free_count <= free_count + 1'b1;
      end else if (do_push & ~pop) begin
         free_count <= free_count - 1'b1;
      end
   end

   // The popped entry is the write to its target register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_strobe <= 1'b0;
         out_data   <= '0;
      end else begin
         out_strobe <= pop;
         if (pop) begin
            out_data <= mem[rd_ptr];
         end
      end
   end

endmodule

// ### verilog/transfer_fetch.sv
// Purpose: Read-only fetch engine for host buffers.
// Assumes: Memory answers a held request with a one-cycle ack.
// Notes:   One word in flight; the fetched word waits for take.

`timescale 1ns/1ns

module transfer_fetch #(
   parameter int COUNT_W = 16
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Control
   input  wire logic               start,
   input  wire logic [31:0]        start_addr,
   input  wire logic [COUNT_W-1:0] start_count,
   input  wire logic               room,
   output logic [COUNT_W-1:0]      remaining,
   output logic                    done,
   // Host memory read port
   output logic                    mem_req,
   output logic [31:0]             mem_addr,
   input  wire logic [31:0]        mem_rdata,
   input  wire logic               mem_ack,
   // Word stream
   output logic                    word_valid,
   output logic [31:0]             word_data,
   input  wire logic               word_take
);

   // There is no write path to host memory at all.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_req   <= 1'b0;
         mem_addr  <= loader_pkg::RST_WORD;
         remaining <= '0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            mem_addr  <= start_addr;
            remaining <= start_count;
         end else if (mem_req & mem_ack) begin
            mem_req   <= 1'b0;
            mem_addr  <= mem_addr + loader_pkg::ADDR_STEP;
            remaining <= remaining - 1'b1;
            done      <= (remaining == COUNT_W'(1));
         end else if (~mem_req & ~word_valid & room & (remaining != '0)) begin
            mem_req <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         word_valid <= 1'b0;
         word_data  <= loader_pkg::RST_WORD;
      end else if (mem_req & mem_ack) begin
         word_valid <= 1'b1;
         word_data  <= mem_rdata;
      end else if (word_take) begin
         word_valid <= 1'b0;
      end
   end

endmodule

// ### verif/loader_asserts.sv
// Purpose: Port checks for the tagged input loader.
// Assumes: The bus master holds each request until ack.
// Notes:   Bound into every loader instance.
`timescale 1ns/1ns
module loader_asserts #(
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Memory, drain and interrupt
   input wire logic        mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_rdata,
   input wire logic        mem_ack,
   input wire logic        drain_req,
   input wire logic        entry_strobe,
   input wire logic [8:0]  entry_tag,
   input wire logic [31:0] entry_data,
   input wire logic        irq
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic rd_ack;
   assign rd_ack = wb_ack_o && !wb_we_i;
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Bus request not answered in the next cycle.");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Bus ack longer than one cycle.");
   free_bound_a: assert property (rd_ack && wb_adr_i == 16'h0000 |-> wb_dat_o <= DEPTH)
      else $error("Free count above queue depth.");
   win_read_a: assert property (rd_ack && wb_adr_i[15:12] == 4'h2 |-> wb_dat_o == 32'h0)
      else $error("Window read returned data.");
   entry_cause_a: assert property (entry_strobe |-> $past(drain_req))
      else $error("Entry issued without a drain request.");
   mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("Memory request dropped or moved before ack.");
   mem_step_a: assert property (mem_req && mem_ack |=> !mem_req
      && mem_addr == $past(mem_addr) + 32'h4)
      else $error("Memory address did not step by one word.");
   mem_gap_a: assert property ($fell(mem_req) |-> !mem_req ##1 !mem_req)
      else $error("Memory requests closer than two idle cycles.");
   cover property (rd_ack && wb_adr_i == 16'h0000 && wb_dat_o == 32'h0);
   cover property (mem_req && mem_ack && !drain_req);
   cover property (entry_strobe && drain_req);
   cover property (irq);
endmodule

bind tagged_input_loader loader_asserts #(.DEPTH(DEPTH)) loader_asserts_inst (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
   .mem_ack(mem_ack), .drain_req(drain_req), .entry_strobe(entry_strobe),
   .entry_tag(entry_tag), .entry_data(entry_data), .irq(irq));

// ### verif/host_mem_model.sv
// Purpose: Host memory holding transfer buffers.
// Assumes: Requests are held until acknowledged.
// Notes:   Answers after one to four cycles; data toggles when idle.
`timescale 1ns/1ns
module host_mem_model (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Read port
   input wire logic        mem_req,
   input wire logic [31:0] mem_addr,
   output logic [31:0]     mem_rdata,
   output logic            mem_ack
);
   logic [31:0] mem [0:255];
   int          wait_cnt;
   int          seed = 43;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         wait_cnt <= 0;
      end else begin
         mem_ack <= 1'b0;
         if (mem_req && !mem_ack && wait_cnt == 0) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[9:2]];
         end else begin
            mem_rdata <= ~mem_rdata;
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt - 1 : $unsigned($random(seed)) % 4;
         end
      end
   end
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the tagged input loader.
// Assumes: Host memory model on the fetch port.
// Notes:   Drained entries are compared in order against a queue.
`timescale 1ns/1ns
module tb_top;
   logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, drain_req;
   logic        mem_req, mem_ack, entry_strobe, irq;
   logic [15:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, mem_addr, mem_rdata, entry_data, rd, w;
   logic [8:0]  entry_tag;
   logic [40:0] exp_q[$];
   logic [31:0] buf_q[$];
   int          err_total, n_checks, cycles, seed, i;
   // ----------------------------------------------------------------
   // Design and partner
   // ----------------------------------------------------------------
   tagged_input_loader tagged_input_loader_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .drain_req(drain_req),
      .entry_strobe(entry_strobe), .entry_tag(entry_tag), .entry_data(entry_data), .irq(irq));
   host_mem_model host_mem_model_inst (.clk(clk), .rst(rst), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("Checks %0d, errors %0d.", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [40:0] exp, input logic [40:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hF;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic add_grp(input logic [31:0] d);
      int n;
      n = (d[15:14] == 2'h2) ? $countones(d[31:16]) : d[31:16] + 1;
      buf_q.push_back(d);
      repeat (n) buf_q.push_back($random(seed));
   endtask
   function automatic void expand();
      int p, k, n;
      logic [31:0] d;
      logic [8:0]  t;
      p = 0;
      while (p < buf_q.size()) begin
         d = buf_q[p];
         t = d[8:0];
         p++;
         n = (d[15:14] == 2'h2) ? 16 : d[31:16] + 1;
         for (k = 0; k < n; k++) begin
            if (d[15:14] != 2'h2) begin
               exp_q.push_back({t, buf_q[p]});
               p++;
               if (d[15:14] == 2'h1) t = t + 9'h1;
            end else if (d[16+k]) begin
               exp_q.push_back({t[8:4], k[3:0], buf_q[p]});
               p++;
            end
         end
      end
   endfunction
   task automatic wait_empty();
      drain_req <= 1'b1;
      for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      check("entries left", 41'h0, 41'(exp_q.size()));
   endtask
   task automatic poll_done();
      for (int k = 0; k < 3000; k++) begin
         drain_req <= w[k%32];
         wb_xfer(1'b0, loader_pkg::OFS_COUNT, 32'h0);
         if (rd[15:0] == 16'h0) break;
      end
      check("count end", 41'h0, {9'h0, rd});
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         complete_run();
      end
      if (entry_strobe === 1'b1 && exp_q.size() == 0) check("extra entry", 41'h0, 41'h1);
      else if (entry_strobe === 1'b1)
         check("entry", exp_q.pop_front(), {entry_tag, entry_data});
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 43;
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 16'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      drain_req = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb_xfer(1'b0, loader_pkg::OFS_FREE, 32'h0);
      check("free at reset", 41'h20, {9'h0, rd});
      for (i = 0; i < 33; i++) begin
         w = $random(seed);
         if (i < 32) exp_q.push_back({w[8:0], ~w});
         wb_xfer(1'b1, {4'h4, w[8:0], 3'h0}, ~w);
         if (i == 9) wb_xfer(1'b0, loader_pkg::OFS_FREE, 32'h0);
         if (i == 9) check("free partial", 41'h16, {9'h0, rd});
      end
      wb_xfer(1'b0, loader_pkg::OFS_FREE, 32'h0);
      check("free full", 41'h0, {9'h0, rd});
      wait_empty();
      wb_xfer(1'b0, loader_pkg::OFS_FREE, 32'h0);
      check("free drained", 41'h20, {9'h0, rd});
      w = $random(seed);
      add_grp({23'h0, w[8:0]});
      add_grp({16'h0002, 7'h0, w[16:8]});
      add_grp(32'h0007_41F8);
      add_grp(32'h0032_80F0);
      add_grp(32'h0000_8030);
      add_grp(32'h0001_C0AB);
      expand();
      for (i = 0; i < buf_q.size(); i++) begin
         w = $random(seed);
         wb_xfer(1'b1, {4'h2, w[11:2], 2'h0}, buf_q[i]);
      end
      wb_xfer(1'b0, 16'h2FFC, 32'h0);
      check("window read", 41'h0, {9'h0, rd});
      wait_empty();
      buf_q.delete();
      add_grp({16'h0027, 7'h0, w[8:0]});
      add_grp({16'h0003, 7'h20, w[20:12]});
      add_grp({w[31:16] | 16'h8001, 16'h8120});
      add_grp({23'h0, w[29:21]});
      for (i = 0; i < buf_q.size(); i++) host_mem_model_inst.mem[i] = buf_q[i];
      expand();
      drain_req <= 1'b0;
      wb_xfer(1'b1, loader_pkg::OFS_IEN, 32'h1);
      wb_xfer(1'b1, loader_pkg::OFS_BASE, 32'h0);
      wb_xfer(1'b1, loader_pkg::OFS_COUNT, 32'(buf_q.size()));
      wb_xfer(1'b1, loader_pkg::OFS_BASE, 32'h200);
      wb_xfer(1'b0, loader_pkg::OFS_BASE, 32'h0);
      check("base read", 41'h200, {9'h0, rd});
      repeat (400) @(posedge clk);
      wb_xfer(1'b0, loader_pkg::OFS_FREE, 32'h0);
      check("free stalled", 41'h0, {9'h0, rd});
      w = $random(seed);
      poll_done();
      wait_empty();
      wb_xfer(1'b0, loader_pkg::OFS_IFLAG, 32'h0);
      check("done flag", 41'h1, {9'h0, rd});
      check("irq set", 41'h1, {40'h0, irq});
      wb_xfer(1'b1, loader_pkg::OFS_IFLAG, 32'h1);
      wb_xfer(1'b0, loader_pkg::OFS_IFLAG, 32'h0);
      check("flag cleared", 41'h0, {9'h0, rd});
      check("irq clear", 41'h0, {40'h0, irq});
      wb_xfer(1'b1, loader_pkg::OFS_BASE, 32'h0);
      expand();
      wb_xfer(1'b1, loader_pkg::OFS_COUNT, 32'(buf_q.size()));
      poll_done();
      wait_empty();
      complete_run();
   end
endmodule
